// *** rtl/stepper_translator_chopper.v ***
// Notes on behaviour
// - fixed off-time one-shot after each trip
// - timing pin high selects 30 us default
// - ignore comparators for blank time after switching
// - enable input high forces outputs off
// - translator runs regardless of enable
// - overtemperature or pump undervoltage disables outputs
// - power-on lockout disables outputs, homes translator
// - regulator fault disables bridge outputs
// - mixed decay: fast 31.25 percent, then slow
// - synchronous rectification on during off-time
// - zero current stops synchronous rectification
// - home is half-step entry 2, 70.71 both
// - eight-entry table; full step walks even entries
// - rising step advances, direction sampled there
// - reset low homes, outputs off, ignores steps
// - size select low full, high half
// - lower target or home state mixed decay, else slow
`timescale 1ns/10ps
`include "stepper_defs.vh"

module stepper_translator_chopper (
    input  wire        CLK_IN,           // 250 MHz clock
    input  wire        RST_N_IN,         // async reset, active low
    input  wire        STEP_IN,          // step pin
    input  wire        DIR_IN,           // direction pin
    input  wire        STEP_SIZE_SELECT_IN, // low full, high half
    input  wire        RESET_N_IN,       // translator reset pin, active low
    input  wire        ENABLE_N_IN,      // output enable pin, active low
    input  wire        TIMER_PIN_HIGH_IN, // timing pin above 3 V
    input  wire        OVERTEMP_IN,      // thermal fault
    input  wire        PUMP_UV_IN,       // gate pump reservoir undervoltage
    input  wire        REG_FAULT_IN,     // sink gate regulator fault
    input  wire        UV_LOCKOUT_IN,    // supply undervoltage lockout
    input  wire [1:0]  TRIP_IN,          // sense comparators, per phase
    input  wire [1:0]  ZERO_CUR_IN,      // zero current detect, per phase
    input  wire        HSEL,             // ahb select
    input  wire [31:0] HADDR,            // ahb address
    input  wire [1:0]  HTRANS,           // ahb transfer type
    input  wire        HWRITE,           // ahb write
    input  wire [2:0]  HSIZE,            // ahb size
    input  wire [31:0] HWDATA,           // ahb write data
    input  wire        HREADY,           // ahb bus ready
    output wire [31:0] HRDATA,           // ahb read data
    output wire        HREADYOUT,        // slave ready
    output wire        HRESP,            // always okay
    output wire [3:0]  BRIDGE1_OUT,      // src a, sink a, src b, sink b
    output wire [3:0]  BRIDGE2_OUT,      // same layout, phase 2
    output wire [7:0]  TARGET1_OUT,      // signed phase 1 target, 100 = full
    output wire [7:0]  TARGET2_OUT,      // signed phase 2 target
    output wire        IRQ_OUT           // level interrupt
);

// ****************************************************************
// pin synchronisers
// ****************************************************************
localparam NSYNC = 16;
wire [NSYNC-1:0] raw_in = {ZERO_CUR_IN, TRIP_IN, UV_LOCKOUT_IN, REG_FAULT_IN, PUMP_UV_IN, OVERTEMP_IN,
                           TIMER_PIN_HIGH_IN, ENABLE_N_IN, RESET_N_IN, STEP_SIZE_SELECT_IN, DIR_IN, STEP_IN,
                           2'b00};
reg  [NSYNC-1:0] meta_ff;
reg  [NSYNC-1:0] sync_ff;
// two stages; only sync_ff is read
always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
        meta_ff <= 16'h0000;
        sync_ff <= 16'h0000;
    end else begin
        meta_ff <= raw_in;
        sync_ff <= meta_ff;
    end
end
// synchronised pin levels; bits 1:0 are spare and stay low
wire       step_s  = sync_ff[2];
wire       dir_s   = sync_ff[3];
wire       half_s  = sync_ff[4];
wire       rstn_s  = sync_ff[5];
wire       en_n_s  = sync_ff[6];
wire       tpin_s  = sync_ff[7];
wire       fault_s = sync_ff[8] | sync_ff[9] | sync_ff[10] | sync_ff[11];
wire [1:0] trip_s  = sync_ff[13:12];
wire [1:0] zero_s  = sync_ff[15:14];

// ****************************************************************
// register bus
// ****************************************************************
reg         ctrl_ff;
reg  [3:0]  irq_stat_ff;
reg  [3:0]  irq_mask_ff;
reg  [15:0] off_cfg_ff;
reg         wr_pend_ff;
reg  [7:0]  addr_ff;
reg  [31:0] rdata_ff;
wire        take = HSEL & HREADY & HTRANS[1];
wire        wr_now = wr_pend_ff;
wire [3:0]  ev;
// capture the address phase; write lands in the data phase
always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
        wr_pend_ff <= 1'b0;
        addr_ff    <= 8'h00;
    end else begin
        wr_pend_ff <= take & HWRITE;
        addr_ff    <= HADDR[7:0];
    end
end
// writable registers; event set wins over a one-to-clear
always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
        ctrl_ff     <= 1'b0;
        irq_mask_ff <= 4'h0;
        irq_stat_ff <= 4'h0;
        off_cfg_ff  <= 16'h0FA0;
    end else begin
        if (wr_now && addr_ff == `REG_CTRL)
            ctrl_ff <= HWDATA[`CTRL_USE_RES];
        if (wr_now && addr_ff == `REG_IRQ_MASK)
            irq_mask_ff <= HWDATA[3:0];
        if (wr_now && addr_ff == `REG_OFF_CFG)
            off_cfg_ff <= HWDATA[15:0];
        irq_stat_ff <= (irq_stat_ff & ~((wr_now && addr_ff == `REG_IRQ_STAT) ? HWDATA[3:0] : 4'h0)) | ev;
    end
end

// ****************************************************************
// translator
// ****************************************************************
reg  [2:0] idx_ff;
reg        step_d_ff;
reg  [1:0] mixed_ff;
reg  [7:0] tgt1_ff;
reg  [7:0] tgt2_ff;
wire       step_rise = step_s & ~step_d_ff;
wire       homing = ~rstn_s | sync_ff[11];
// table entry to signed percent (70.71 rounded to 71)
function [7:0] pct;
    input [2:0] i;
    input       ph2;
    reg   [2:0] j;
    begin
        j = ph2 ? i - 3'h2 : i;
        case (j)
            3'h0: pct = 8'h64;
            3'h1: pct = 8'h47;
            3'h2: pct = 8'h00;
            3'h3: pct = 8'hB9;
            3'h4: pct = 8'h9C;
            3'h5: pct = 8'hB9;
            3'h6: pct = 8'h00;
            default: pct = 8'h47;
        endcase
    end
endfunction
// magnitude of a signed percent
function [6:0] mag;
    input [7:0] v;
    begin
        mag = v[7] ? 7'h00 - v[6:0] : v[6:0];
    end
endfunction
// index counts entries from 0, so home (entry 2) is index 1
wire [2:0] inc   = half_s ? 3'h1 : 3'h2;
wire [2:0] base  = half_s ? idx_ff : (idx_ff | 3'h1);
wire [2:0] nxt_idx = dir_s ? base + inc : base - inc;
// step handling runs regardless of enable and of every fault except lockout, which homes
// translator independent
always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
        step_d_ff <= 1'b0;
        idx_ff    <= `HOME_IDX;
        mixed_ff  <= 2'b11;
    end else begin
        step_d_ff <= step_s;
        // reset homes, lockout homes, home entry
        if (homing) begin
            idx_ff   <= `HOME_IDX;
            mixed_ff <= 2'b11;
        end else if (step_rise) begin
            idx_ff      <= nxt_idx;
            mixed_ff[0] <= mag(pct(nxt_idx, 1'b0)) < mag(pct(idx_ff, 1'b0));
            mixed_ff[1] <= mag(pct(nxt_idx, 1'b1)) < mag(pct(idx_ff, 1'b1));
        end
    end
end

// ****************************************************************
// target outputs
// ****************************************************************
// targets leave from flip-flops; the extra cycle is small beside the
// two-flop lag on the step pin, and keeps the table decode off the pins
always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
        tgt1_ff <= `HOME_PCT;
        tgt2_ff <= `HOME_PCT;
    end else begin
        tgt1_ff <= pct(idx_ff, 1'b0);
        tgt2_ff <= pct(idx_ff, 1'b1);
    end
end
// the chopper below reads these same registered targets
assign TARGET1_OUT = tgt1_ff;
assign TARGET2_OUT = tgt2_ff;

// ****************************************************************
// off-time selection
// ****************************************************************
// default off-time, loaded length
wire [15:0] off_len  = (tpin_s | ~ctrl_ff) ? `OFF_DEF_CYC : off_cfg_ff;
// a loaded length of zero still keeps the bridges off for one cycle
// fast share is 5/16 of the off-time, rounded down to whole cycles
wire [19:0] fast_pr  = {4'h0, off_len} * `FAST_NUM;
wire [15:0] fast_len = fast_pr[19:4];
wire        out_ok   = ~en_n_s & ~fault_s & rstn_s;
reg         out_ok_d_ff;
// bridges coming back on after enable or a fault switch as well
wire        rearm    = out_ok & ~out_ok_d_ff;
// previous gate state, to spot the outputs returning
always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN)
        out_ok_d_ff <= 1'b0;
    else
        out_ok_d_ff <= out_ok;
end

// ****************************************************************
// chopper per phase
// ****************************************************************
// no pattern below turns on the source and sink of one leg together
localparam S_DRIVE = 2'b01;
localparam S_OFF   = 2'b10;
wire [1:0] trip_ev;
genvar p;
generate
    for (p = 0; p < 2; p = p + 1) begin : g_ph
        reg  [1:0]  st_ff;
        reg  [15:0] off_cnt_ff;
        reg  [15:0] blank_cnt_ff;
        reg         nosync_ff;
        reg  [3:0]  br_ff;
        wire [7:0]  tgt   = p ? TARGET2_OUT : TARGET1_OUT;
        wire        pos   = ~tgt[7];
        wire        zero  = tgt == 8'h00;
        wire        fast  = mixed_ff[p] && (off_len - off_cnt_ff) < fast_len;
        wire        trip  = trip_s[p] && blank_cnt_ff == 16'h0000 && st_ff == S_DRIVE;
        reg  [3:0]  nxt_br;
        assign trip_ev[p] = trip;
        // chop state and counters
        always @(posedge CLK_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                st_ff        <= S_DRIVE;
                off_cnt_ff   <= 16'h0000;
                blank_cnt_ff <= `BLANK_CYC;
                nosync_ff    <= 1'b0;
            end else begin
                case (st_ff)
                    S_DRIVE: begin
                        // transients of re-enabled bridges are blanked too
                        if (rearm)
                            blank_cnt_ff <= `BLANK_CYC;
                        else if (blank_cnt_ff != 16'h0000)
                            blank_cnt_ff <= blank_cnt_ff - 16'h0001;
                        if (trip) begin
                            st_ff        <= S_OFF;
                            off_cnt_ff   <= off_len;
                            blank_cnt_ff <= `BLANK_CYC;
                            nosync_ff    <= 1'b0;
                        end
                    end
                    S_OFF: begin
                        if (zero_s[p])
                            nosync_ff <= 1'b1;
                        if (off_cnt_ff <= 16'h0001) begin
                            st_ff        <= S_DRIVE;
                            blank_cnt_ff <= `BLANK_CYC;
                        end else
                            off_cnt_ff <= off_cnt_ff - 16'h0001;
                    end
                    default: st_ff <= S_DRIVE;
                endcase
            end
        end
        // gate pattern: {src a, sink a, src b, sink b}
        always @* begin
            nxt_br = 4'h0;
            if (zero)
                nxt_br = 4'h0;
            else if (st_ff == S_DRIVE)
                nxt_br = pos ? 4'b1001 : 4'b0110;
            else if (fast)
                nxt_br = nosync_ff ? 4'h0 : (pos ? 4'b0110 : 4'b1001);
            // sync rectification, slow decay on low side
            else
                nxt_br = nosync_ff ? (pos ? 4'b0001 : 4'b0100) : 4'b0101;
            if (!out_ok)
                nxt_br = 4'h0;
        end
        // gate drive leaves from a flip-flop, so the pins never glitch
        always @(posedge CLK_IN or negedge RST_N_IN) begin
            if (!RST_N_IN)
                br_ff <= 4'h0;
            else
                br_ff <= nxt_br;
        end
    end
endgenerate
// per-phase gate registers to the pins
assign BRIDGE1_OUT = g_ph[0].br_ff;
assign BRIDGE2_OUT = g_ph[1].br_ff;

// ****************************************************************
// interrupts and readback
// ****************************************************************
// a step event counts only when the translator really moves
assign ev = {step_rise & ~homing, fault_s, trip_ev};
assign IRQ_OUT = |(irq_stat_ff & irq_mask_ff);
// read mux registered in the data phase
always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN)
        rdata_ff <= 32'h0000_0000;
    else if (take && !HWRITE) begin
        case (HADDR[7:0])
            `REG_CTRL:     rdata_ff <= {31'h0, ctrl_ff};
            `REG_STATUS:   rdata_ff <= {20'h0, out_ok, fault_s, mixed_ff, 5'h0, idx_ff};
            `REG_IRQ_STAT: rdata_ff <= {28'h0, irq_stat_ff};
            `REG_IRQ_MASK: rdata_ff <= {28'h0, irq_mask_ff};
            `REG_OFF_CFG:  rdata_ff <= {16'h0, off_cfg_ff};
            default:       rdata_ff <= 32'h0000_0000;
        endcase
    end
end
// zero wait states, never an error; transfer size is not checked
assign HRDATA    = rdata_ff;
assign HREADYOUT = 1'b1;
assign HRESP     = 1'b0;

endmodule // stepper_translator_chopper

// *** rtl/stepper_defs.vh ***
`ifndef STEPPER_DEFS_VH
`define STEPPER_DEFS_VH
// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_IRQ_STAT    8'h08
`define REG_IRQ_MASK    8'h0C
`define REG_OFF_CFG     8'h10
// ****************************************************************
// control register fields
// ****************************************************************
`define CTRL_USE_RES    0
`define CTRL_RESET      32'h0000_0001
// ****************************************************************
// interrupt bits
// ****************************************************************
`define IRQ_TRIP1       0
`define IRQ_TRIP2       1
`define IRQ_FAULT       2
`define IRQ_STEP        3
`define IRQ_W           4
// ****************************************************************
// timing
// ****************************************************************
`define CLK_MHZ         250
`define OFF_DEF_US      30
`define OFF_DEF_CYC     16'h1D4C
`define BLANK_US        1
`define BLANK_CYC       16'h00FA
`define FAST_NUM        20'h00005
`define FAST_DEN        16
`define HOME_IDX        3'h1
`define HOME_PCT        8'h47
`define CNT_W           16
`endif

// *** verification/step_controller.sv ***
`timescale 1ns/10ps
// step and direction controller that sits in front of the translator
module step_controller (
    input  wire logic clk_in,       // bench clock
    output logic      step_out,     // step pulse
    output logic      dir_out,      // direction level
    output logic      size_out,     // low full, high half
    output logic      reset_n_out,  // translator reset, active low
    output logic      enable_n_out  // output enable, active low
);
    initial begin
        {step_out, dir_out, size_out, reset_n_out, enable_n_out} = 5'b00110;
    end
    // one step; pulse widths of 1 us so the synchroniser never misses an edge
    task automatic pulse(input logic dir);
        @(posedge clk_in) dir_out <= dir;
        repeat (50) @(posedge clk_in);
        step_out <= 1'b1;
        repeat (250) @(posedge clk_in);
        step_out <= 1'b0;
        repeat (250) @(posedge clk_in);
    endtask
endmodule // step_controller

// *** verification/stepper_asserts.sv ***
`timescale 1ns/10ps
module stepper_asserts (
    input wire logic       CLK_IN,       // clock
    input wire logic       RST_N_IN,     // reset
    input wire logic       STEP_IN,      // step
    input wire logic       RESET_N_IN,   // translator reset
    input wire logic       ENABLE_N_IN,  // enable
    input wire logic       OVERTEMP_IN,  // thermal
    input wire logic       PUMP_UV_IN,   // pump low
    input wire logic       REG_FAULT_IN, // regulator
    input wire logic       UV_LOCKOUT_IN,// lockout
    input wire logic       HREADYOUT,    // ready
    input wire logic       HRESP,        // response
    input wire logic [3:0] BRIDGE1_OUT,  // bridge 1
    input wire logic [3:0] BRIDGE2_OUT,  // bridge 2
    input wire logic [7:0] TARGET1_OUT,  // target 1
    input wire logic [7:0] TARGET2_OUT   // target 2
);
    logic home, off;
    // six cycles covers the two-flop input lag plus the output register
    assign home = TARGET1_OUT == 8'h47 && TARGET2_OUT == 8'h47;
    assign off  = BRIDGE1_OUT == 4'h0 && BRIDGE2_OUT == 4'h0;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    sequence step_edge;
        !STEP_IN ##1 STEP_IN && RESET_N_IN && !UV_LOCKOUT_IN;
    endsequence
    sequence target_moves;
        ##[1:8] $changed({TARGET1_OUT, TARGET2_OUT});
    endsequence
    enable_off_a: assert property (ENABLE_N_IN [*6] |-> off) else $error("outputs on while disabled");
    thermal_pump_off_a: assert property ((OVERTEMP_IN || PUMP_UV_IN) [*6] |-> off)
        else $error("outputs on during fault");
    regulator_off_a: assert property (REG_FAULT_IN [*6] |-> off) else $error("outputs on, regulator fault");
    lockout_home_a: assert property (UV_LOCKOUT_IN [*6] |-> off && home) else $error("lockout not homed");
    reset_pin_home_a: assert property (!RESET_N_IN [*6] |-> off && home) else $error("reset not homed");
    step_advance_a: assert property (step_edge |-> target_moves) else $error("step edge ignored");
    home_release_a: assert property ($rose(RST_N_IN) |-> home) else $error("not home after reset");
    bus_okay_a: assert property (HREADYOUT && !HRESP) else $error("bus not ready or error");
endmodule // stepper_asserts
bind stepper_translator_chopper stepper_asserts chk_u (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .STEP_IN(STEP_IN),
    .RESET_N_IN(RESET_N_IN), .ENABLE_N_IN(ENABLE_N_IN), .OVERTEMP_IN(OVERTEMP_IN), .PUMP_UV_IN(PUMP_UV_IN),
    .REG_FAULT_IN(REG_FAULT_IN), .UV_LOCKOUT_IN(UV_LOCKOUT_IN), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .BRIDGE1_OUT(BRIDGE1_OUT), .BRIDGE2_OUT(BRIDGE2_OUT), .TARGET1_OUT(TARGET1_OUT), .TARGET2_OUT(TARGET2_OUT));

// *** verification/stepper_translator_chopper_test.sv ***
`timescale 1ns/10ps
module stepper_translator_chopper_test;
    logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, timer_hi = 0;
    logic [3:0]  flt = 0;
    logic [1:0]  trip = 0, zc = 0, htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, q;
    wire  [31:0] hrdata;
    wire  [3:0]  br1, br2;
    wire  [7:0]  t1, t2;
    wire         hready, hresp, irq, stp, dir, size, rp_n, en_n;
    logic [2:0]  idx = 3'h1;
    int          fail_count = 0, tests_run = 0, cyc = 0;
    // signed percent pairs per entry, 71 standing for 70.71
    logic [15:0] tbl [0:7] = '{16'h6400, 16'h4747, 16'h0064, 16'hB947, 16'h9C00, 16'hB9B9, 16'h009C, 16'h47B9};
    always #2 clk = ~clk;
    step_controller ctl_u (.clk_in(clk), .step_out(stp), .dir_out(dir), .size_out(size), .reset_n_out(rp_n),
        .enable_n_out(en_n));
    stepper_translator_chopper dut_u (.CLK_IN(clk), .RST_N_IN(rst_n), .STEP_IN(stp), .DIR_IN(dir),
        .STEP_SIZE_SELECT_IN(size), .RESET_N_IN(rp_n), .ENABLE_N_IN(en_n), .TIMER_PIN_HIGH_IN(timer_hi),
        .OVERTEMP_IN(flt[0]), .PUMP_UV_IN(flt[1]), .REG_FAULT_IN(flt[2]), .UV_LOCKOUT_IN(flt[3]),
        .TRIP_IN(trip), .ZERO_CUR_IN(zc), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .BRIDGE1_OUT(br1), .BRIDGE2_OUT(br2), .TARGET1_OUT(t1), .TARGET2_OUT(t2), .IRQ_OUT(irq));
    // one single word transfer; waits on ready in both phases
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h0, a};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q & msk, exp, "register read");
    endtask
    task automatic tgt(); chk({t1, t2}, tbl[idx], "target pair"); endtask
    task automatic offc(); chk({br1, br2}, 8'h00, "bridges off"); endtask
    task automatic done(input string n); $display("test %s finished", n); endtask
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // cut a hang short; the whole sequence needs about 16600 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            $display("MISMATCH at %0t: timeout", $time);
            end_of_test();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        tgt();
        rdc(8'h10, 32'hFFFF, 32'h0FA0);
        rdc(8'h04, 32'h7, 32'h1);
        rdc(8'h20, 32'hFFFFFFFF, 32'h0);
        done("reset");
        bus(1'b1, 8'h0C, 32'hF);
        for (int i = 0; i < 8; i++) begin
            ctl_u.pulse(1'b1);
            idx = idx + 3'h1;
            tgt();
            rdc(8'h04, 32'h7, {29'h0, idx});
            // first step: phase 1 falls to 0, phase 2 rises to 100
            if (i == 0) rdc(8'h04, 32'h300, 32'h100);
            if (i == 1) rdc(8'h04, 32'h300, 32'h200);
        end
        chk(irq, 1'b1, "irq raised");
        bus(1'b1, 8'h08, 32'hF);
        @(posedge clk);
        chk(irq, 1'b0, "irq cleared");
        bus(1'b1, 8'h0C, 32'h0);
        ctl_u.size_out <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            ctl_u.pulse(1'b0);
            idx = idx - 3'h2;
            tgt();
        end
        rdc(8'h08, 32'h8, 32'h8);
        chk(irq, 1'b0, "masked irq");
        done("stepping");
        ctl_u.enable_n_out <= 1'b1;
        ctl_u.pulse(1'b1);
        idx = idx + 3'h2;
        offc();
        tgt();
        ctl_u.enable_n_out <= 1'b0;
        repeat (10) @(posedge clk);
        chk(br1 != 4'h0 && br2 != 4'h0, 1'b1, "bridges driven");
        for (int k = 0; k < 3; k++) begin
            flt <= 4'h1 << k;
            repeat (10) @(posedge clk);
            offc();
            rdc(8'h04, 32'h400, 32'h400);
            flt <= 4'h0;
            repeat (10) @(posedge clk);
        end
        flt <= 4'h8;
        repeat (10) @(posedge clk);
        idx = 3'h1;
        tgt();
        flt <= 4'h0;
        done("enable and faults");
        ctl_u.reset_n_out <= 1'b0;
        ctl_u.pulse(1'b1);
        tgt();
        offc();
        ctl_u.reset_n_out <= 1'b1;
        bus(1'b1, 8'h10, 32'h40);
        bus(1'b1, 8'h00, 32'h1);
        repeat (300) @(posedge clk);
        // trip seen after the two-flop lag; 64-cycle off-time, first 20 fast
        trip <= 2'h3;
        repeat (10) @(posedge clk);
        chk({br1, br2}, 8'h66, "fast decay");
        trip <= 2'h0;
        repeat (30) @(posedge clk);
        chk({br1, br2}, 8'h55, "slow decay");
        repeat (30) @(posedge clk);
        trip <= 2'h3;
        chk({br1, br2}, 8'h99, "drive after off-time");
        repeat (10) @(posedge clk);
        chk({br1, br2}, 8'h99, "trip blanked");
        trip <= 2'h0;
        rdc(8'h08, 32'h3, 32'h3);
        done("reset pin and trip");
        // timing pin high: 7500-cycle off-time whatever the register holds
        timer_hi <= 1'b1;
        repeat (300) @(posedge clk);
        trip <= 2'h3;
        repeat (3000) @(posedge clk);
        trip <= 2'h0;
        chk({br1, br2}, 8'h55, "default off-time");
        zc <= 2'h3;
        repeat (10) @(posedge clk);
        chk({br1, br2}, 8'h11, "zero current");
        zc <= 2'h0;
        repeat (5000) @(posedge clk);
        chk({br1, br2}, 8'h99, "one-shot expired");
        done("off-time");
        end_of_test();
    end
endmodule // stepper_translator_chopper_test
